// ---- pmsr_mgmt_model.sv ----
// Management controller model: one-cycle register accesses.
// Assumes the block takes a request on a rising mclk edge.
`default_nettype none
module pmsr_mgmt_model
  import pmsr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Request port
  output pmsr_req_t req,
  output logic req_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req = '0;
    req_valid = 1'b0;
  end
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] data);
    @(posedge mclk);
    #1;
    req.wr = wr;
    req.idx = idx;
    req.data = data;
    if (wr && idx == IDX_SPECIAL)
      req.data[BIT_WR_ONE] = 1'b1;
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    // Released bus shows inverted data, never a stale copy
    req.data = ~req.data;
  endtask
endmodule
`default_nettype wire

// ---- pmsr_pkg.sv ----
// Package for the transceiver mode and status register group.
// Assumes a management port delivers register index, write strobe and data.
`default_nettype none
package pmsr_pkg;
  // ---------------------------------------------------------------
  // Register indexes and widths
  // ---------------------------------------------------------------
  localparam int REG_W = 16;
  localparam logic [4:0] IDX_MODE_CTL = 5'h11;
  localparam logic [4:0] IDX_SPECIAL = 5'h12;
  localparam logic [4:0] IDX_SYM_ERR = 5'h1A;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_EDPD = 13;
  localparam int BIT_REMOTE_LOOP = 9;
  localparam int BIT_ALT_IRQ = 6;
  localparam int BIT_ENERGY = 1;
  localparam int BIT_SPARE0 = 0;
  localparam int BIT_WR_ONE = 14;
  localparam int MODE_LO = 5;
  localparam int MODE_HI = 7;
  localparam int ADDR_LO = 0;
  localparam int ADDR_HI = 4;
  // ---------------------------------------------------------------
  // Timing: energy quiet window of 256 ms at 125 MHz
  // ---------------------------------------------------------------
  localparam int ENERGY_QUIET_MS = 256;
  localparam int CLK_MHZ = 125;
  localparam int ENERGY_QUIET_CYC = ENERGY_QUIET_MS * 1000 * CLK_MHZ;
  localparam logic [REG_W-1:0] SYM_ERR_RESET = 16'h0000;
  localparam logic [REG_W-1:0] ZERO16 = 16'h0000;
  // Management request carrier
  typedef struct packed {
    logic wr;
    logic [4:0] idx;
    logic [REG_W-1:0] data;
  } pmsr_req_t;
  // Receive-side events from the link domain
  typedef struct packed {
    logic sym_bad;
    logic in_packet;
    logic energy;
  } pmsr_rx_t;
endpackage
`default_nettype wire

// ---- pmsr_regs.sv ----
// Mode control, special mode and symbol error registers.
// Receive path runs on link_clk; management port and registers on mclk.
//
// Notes on behaviour
// (R1) Bit 13 of register 17 enables energy-detect power-down; reset clear.
// (R2) Bit 9 enables far loopback, echoing received packets, only at 100BASE-TX.
// (R3) Far loopback keeps operating even when the isolate control is set.
// (R4) Bit 6 zero selects primary interrupts, one selects alternate; default zero.
// (R5) Energy-present bit clears after 256 ms without valid line energy.
// (R6) Energy-present sets on hardware reset; soft reset leaves it alone.
// (R7) Controller writes one to register 18 bit 14 and ignores its readback.
// (R8) Register 18 bits 7:5 hold operating mode, reset from mode straps.
// (R9) Register 18 bits 4:0 hold node address, reset from address straps.
// (R10) Invalid symbols at 100BASE-TX, idle included, bump the error counter.
// (R11) Counter advances at most once per received packet.
// (R12) Counter resets to zero and wraps past its maximum.
// (R13) Reserved read-only bits read zero and ignore writes.
`default_nettype none
module pmsr_regs
  import pmsr_pkg::*;
#(
  parameter int QUIET_CYC = ENERGY_QUIET_CYC
)(
  // Clocks and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic link_clk,
  input wire logic link_rst,
  // Straps
  input wire logic [2:0] mode_strap,
  input wire logic [4:0] addr_strap,
  // Management port
  input wire pmsr_req_t req,
  input wire logic req_valid,
  output logic [REG_W-1:0] rd_data,
  // Link side
  input wire pmsr_rx_t rx,
  input wire logic speed_100,
  input wire logic isolate,
  output logic remote_loop_active,
  // Control outputs
  output logic energy_detect_powerdown_en,
  output logic alternate_irq_select,
  output logic line_energy_present,
  output logic [2:0] op_mode,
  output logic [4:0] management_node_address
);
  // ---------------------------------------------------------------
  // Control register state
  // ---------------------------------------------------------------
  logic edpd_reg;
  logic loop_reg;
  logic alt_reg;
  logic spare0_reg;
  logic wr_one_reg;
  logic [2:0] mode_reg;
  logic [4:0] addr_reg;
  logic energy_reg;
  logic [31:0] quiet_cnt_reg;
  logic [REG_W-1:0] sym_cnt_reg;
  logic [REG_W-1:0] rd_next;
  logic strap_pending_reg;
  logic [2:0] mode_s1_reg, mode_s2_reg;
  logic [4:0] addr_s1_reg, addr_s2_reg;
  logic wr_mode, wr_spec;

  assign wr_mode = req_valid && req.wr && req.idx == IDX_MODE_CTL;
  assign wr_spec = req_valid && req.wr && req.idx == IDX_SPECIAL;

  always_ff @(posedge mclk)
  begin
    if (rst || soft_rst)
    begin
      edpd_reg <= 1'b0;
      loop_reg <= 1'b0;
      alt_reg <= 1'b0;
      spare0_reg <= 1'b0;
    end
    else if (wr_mode)
    begin
      edpd_reg <= req.data[BIT_EDPD]; // R1
      loop_reg <= req.data[BIT_REMOTE_LOOP]; // R2
      alt_reg <= req.data[BIT_ALT_IRQ]; // R4
      spare0_reg <= req.data[BIT_SPARE0];
    end
  end

  // Strap pins are asynchronous to mclk; left unreset so reset cannot mask them
  always_ff @(posedge mclk)
  begin
    mode_s1_reg <= mode_strap;
    mode_s2_reg <= mode_s1_reg;
    addr_s1_reg <= addr_strap;
    addr_s2_reg <= addr_s1_reg;
  end

  // Straps sampled one clock after hardware reset release
  always_ff @(posedge mclk)
  begin
    if (rst)
      strap_pending_reg <= 1'b1;
    else
      strap_pending_reg <= 1'b0;
  end

  // Register 18 fields survive a soft reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_one_reg <= 1'b1;
      mode_reg <= 3'h0;
      addr_reg <= 5'h00;
    end
    else if (strap_pending_reg)
    begin
      mode_reg <= mode_s2_reg; // R8
      addr_reg <= addr_s2_reg; // R9
    end
    else if (wr_spec)
    begin
      wr_one_reg <= req.data[BIT_WR_ONE]; // R7
      mode_reg <= req.data[MODE_HI:MODE_LO]; // R8
      addr_reg <= req.data[ADDR_HI:ADDR_LO]; // R9
    end
  end

  // ---------------------------------------------------------------
  // Link domain: error counting and energy sense
  // ---------------------------------------------------------------
  logic err_seen_reg;
  logic err_tgl_reg;
  logic energy_l1_reg, energy_l2_reg;
  logic loop_l1_reg, loop_l2_reg;

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      loop_l1_reg <= 1'b0;
      loop_l2_reg <= 1'b0;
    end
    else
    begin
      loop_l1_reg <= loop_reg;
      loop_l2_reg <= loop_l1_reg;
    end
  end

  // Isolate deliberately not in the term
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      remote_loop_active <= 1'b0;
    else
      remote_loop_active <= loop_l2_reg && speed_100 && rx.in_packet; // R2 R3
  end

  // One count per packet; idle errors count each, gated by a quiet symbol
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      err_seen_reg <= 1'b0;
      err_tgl_reg <= 1'b0;
    end
    else
    begin
      if (speed_100 && rx.sym_bad && !err_seen_reg)
        err_tgl_reg <= ~err_tgl_reg; // R10
      if (rx.in_packet)
        err_seen_reg <= err_seen_reg || (speed_100 && rx.sym_bad); // R11
      else
        err_seen_reg <= speed_100 && rx.sym_bad;
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      energy_l1_reg <= 1'b0;
      energy_l2_reg <= 1'b0;
    end
    else
    begin
      energy_l1_reg <= rx.energy;
      energy_l2_reg <= energy_l1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Crossings into mclk
  // ---------------------------------------------------------------
  logic tgl_m1_reg, tgl_m2_reg, tgl_m3_reg;
  logic en_m1_reg, en_m2_reg;

  // Toggle chain left unreset: clearing it would fake an edge while the toggle is high
  always_ff @(posedge mclk)
  begin
    tgl_m1_reg <= err_tgl_reg;
    tgl_m2_reg <= tgl_m1_reg;
    tgl_m3_reg <= tgl_m2_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      en_m1_reg <= 1'b0;
      en_m2_reg <= 1'b0;
    end
    else
    begin
      en_m1_reg <= energy_l2_reg;
      en_m2_reg <= en_m1_reg;
    end
  end

  // Wraps naturally at the 16-bit width
  always_ff @(posedge mclk)
  begin
    if (rst)
      sym_cnt_reg <= SYM_ERR_RESET; // R12
    else if (tgl_m2_reg != tgl_m3_reg)
      sym_cnt_reg <= sym_cnt_reg + 16'h0001; // R12
  end

  // Soft reset does not touch the energy bit or its timer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      energy_reg <= 1'b1; // R6
      quiet_cnt_reg <= 32'h0000_0000;
    end
    else if (en_m2_reg)
    begin
      energy_reg <= 1'b1;
      quiet_cnt_reg <= 32'h0000_0000;
    end
    else if (quiet_cnt_reg >= 32'(QUIET_CYC - 1))
      energy_reg <= 1'b0; // R5
    else
      quiet_cnt_reg <= quiet_cnt_reg + 32'h0000_0001;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_next = ZERO16; // R13
    unique case (req.idx)
      IDX_MODE_CTL:
      begin
        rd_next[BIT_EDPD] = edpd_reg;
        rd_next[BIT_REMOTE_LOOP] = loop_reg;
        rd_next[BIT_ALT_IRQ] = alt_reg;
        rd_next[BIT_ENERGY] = energy_reg;
        rd_next[BIT_SPARE0] = spare0_reg;
      end
      IDX_SPECIAL:
      begin
        rd_next[BIT_WR_ONE] = wr_one_reg;
        rd_next[MODE_HI:MODE_LO] = mode_reg;
        rd_next[ADDR_HI:ADDR_LO] = addr_reg;
      end
      IDX_SYM_ERR: rd_next = sym_cnt_reg;
      default: rd_next = ZERO16;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rd_data <= ZERO16;
    else if (req_valid && !req.wr)
      rd_data <= rd_next;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      energy_detect_powerdown_en <= 1'b0;
      alternate_irq_select <= 1'b0;
      line_energy_present <= 1'b1;
      op_mode <= 3'h0;
      management_node_address <= 5'h00;
    end
    else
    begin
      energy_detect_powerdown_en <= edpd_reg; // R1
      alternate_irq_select <= alt_reg; // R4
      line_energy_present <= energy_reg;
      op_mode <= mode_reg;
      management_node_address <= addr_reg;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_edpd_write: assert property (@(posedge mclk) disable iff (rst || soft_rst) // R1
    wr_mode |=> edpd_reg == $past(req.data[BIT_EDPD]))
    else $error("power-down enable not written");
  chk_alt_write: assert property (@(posedge mclk) disable iff (rst || soft_rst) // R4
    wr_mode |-> ##2 alternate_irq_select == $past(req.data[BIT_ALT_IRQ], 2))
    else $error("interrupt select not following write");
  chk_loop_gate: assert property (@(posedge link_clk) disable iff (link_rst) // R2
    (!loop_l2_reg || !speed_100) |=> !remote_loop_active)
    else $error("loop active while disabled");
  chk_loop_isolate: assert property (@(posedge link_clk) disable iff (link_rst) // R3
    (loop_l2_reg && speed_100 && rx.in_packet && isolate) |=> remote_loop_active)
    else $error("isolate stopped loop");
  chk_energy_hold: assert property (@(posedge mclk) disable iff (rst) // R5
    en_m2_reg |=> energy_reg)
    else $error("energy bit not set by energy");
  chk_energy_hwrst: assert property (@(posedge mclk) // R6
    rst |=> energy_reg)
    else $error("energy bit not set by hardware reset");
  chk_energy_soft: assert property (@(posedge mclk) disable iff (rst) // R6
    (soft_rst && !en_m2_reg && (!energy_reg || quiet_cnt_reg < 32'(QUIET_CYC - 1)))
      |=> $stable(energy_reg))
    else $error("soft reset moved energy bit");
  chk_spec_write: assert property (@(posedge mclk) disable iff (rst) // R8 R9
    (wr_spec && !strap_pending_reg) |=> addr_reg == $past(req.data[ADDR_HI:ADDR_LO])
      && mode_reg == $past(req.data[MODE_HI:MODE_LO]))
    else $error("special mode write lost");
  chk_strap_load: assert property (@(posedge mclk) // R8 R9
    $fell(rst) |=> mode_reg == $past(mode_strap) && addr_reg == $past(addr_strap))
    else $error("straps not loaded");
  chk_count_reset: assert property (@(posedge mclk) // R12
    rst |=> sym_cnt_reg == SYM_ERR_RESET)
    else $error("counter not cleared by reset");
  chk_count_step: assert property (@(posedge mclk) disable iff (rst) // R10 R12
    (tgl_m2_reg != tgl_m3_reg) |=> sym_cnt_reg == $past(sym_cnt_reg) + 16'h0001)
    else $error("counter step wrong");
  chk_count_once: assert property (@(posedge link_clk) disable iff (link_rst) // R11
    (rx.in_packet && err_seen_reg) |=> $stable(err_tgl_reg))
    else $error("second count in packet");
  chk_rsv_zero: assert property (@(posedge mclk) disable iff (rst) // R13
    (req_valid && !req.wr && req.idx == IDX_MODE_CTL) |=> rd_data[15:14] == 2'h0
      && rd_data[12:10] == 3'h0)
    else $error("reserved bits nonzero");
  chk_spec_rsv: assert property (@(posedge mclk) disable iff (rst) // R13
    (req_valid && !req.wr && req.idx == IDX_SPECIAL) |=> rd_data[15] == 1'b0
      && rd_data[13:8] == 6'h00)
    else $error("reserved special bits nonzero");
endmodule
`default_nettype wire

// ---- tb_pmsr_regs.sv ----
// Testbench for the mode and status register group.
// Assumes the design's assertions are compiled with it.
`default_nettype none
module tb_pmsr_regs
  import pmsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, soft_rst, link_clk, link_rst, speed_100, isolate, rd_seen;
  logic [2:0] mode_strap, op_mode;
  logic [4:0] addr_strap, node_addr;
  logic [15:0] rd_data, s18, d;
  logic loop_act, edpd, alt_irq, energy;
  pmsr_req_t req;
  logic req_valid;
  pmsr_rx_t rx;
  logic [15:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  pmsr_regs #(.QUIET_CYC(50)) u_pmsr_regs (.mclk(mclk), .rst(rst), .soft_rst(soft_rst),
    .link_clk(link_clk), .link_rst(link_rst), .mode_strap(mode_strap),
    .addr_strap(addr_strap), .req(req), .req_valid(req_valid), .rd_data(rd_data),
    .rx(rx), .speed_100(speed_100), .isolate(isolate), .remote_loop_active(loop_act),
    .energy_detect_powerdown_en(edpd), .alternate_irq_select(alt_irq),
    .line_energy_present(energy), .op_mode(op_mode), .management_node_address(node_addr));
  pmsr_mgmt_model u_pmsr_mgmt_model (.mclk(mclk), .req(req), .req_valid(req_valid));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("counts: checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic lnk(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    exp_q.push_back(exp);
    u_pmsr_mgmt_model.access(1'b0, idx, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] data);
    u_pmsr_mgmt_model.access(1'b1, idx, data);
  endtask
  task automatic bad_sym();
    rx.sym_bad = 1'b1;
    lnk(1);
    rx.sym_bad = 1'b0;
    lnk(1);
  endtask
  // ---------------------------------------------------------------
  // Read-data monitor
  // ---------------------------------------------------------------
  always @(posedge mclk) rd_seen <= req_valid && !req.wr;
  always @(negedge mclk)
    if (rd_seen === 1'b1)
      check("rd_data", rd_data, exp_q.pop_front());
  initial
  begin
    #100000;
    err_count++;
    conclude();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(87763));
    mode_strap = 3'($urandom());
    addr_strap = 5'($urandom());
    s18 = {8'h40, mode_strap, addr_strap};
    {rst, link_rst, soft_rst, speed_100, isolate} = 5'b11011;
    rx = '0;
    rx.energy = 1'b1;
    cyc(5);
    rst = 1'b0;
    lnk(2);
    link_rst = 1'b0;
    cyc(2);
    rd(IDX_MODE_CTL, 16'h0002);
    rd(IDX_SPECIAL, s18);
    rd(IDX_SYM_ERR, SYM_ERR_RESET);
    $display("test reset done");
    wr(IDX_MODE_CTL, 16'hFFFF);
    cyc(2);
    check("ctl_outs", {13'h0, edpd, alt_irq, energy}, 16'h0007);
    rd(IDX_MODE_CTL, 16'h2243);
    d = 16'($urandom());
    wr(IDX_SPECIAL, d);
    cyc(2);
    s18 = (d & 16'h40FF) | 16'h4000;
    check("strap_outs", {8'h00, op_mode, node_addr}, {8'h00, d[7:0]});
    rd(IDX_SPECIAL, s18);
    wr(IDX_SYM_ERR, 16'hFFFF);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    rd(IDX_SYM_ERR, 16'h0000);
    $display("test writes done");
    rx.in_packet = 1'b1;
    lnk(3);
    check("loop", {15'h0, loop_act}, 16'h0001);
    bad_sym();
    bad_sym();
    rx.in_packet = 1'b0;
    lnk(2);
    bad_sym();
    bad_sym();
    speed_100 = 1'b0;
    rx.in_packet = 1'b1;
    bad_sym();
    lnk(2);
    check("loop_off", {15'h0, loop_act}, 16'h0000);
    rx.in_packet = 1'b0;
    cyc(10);
    rd(IDX_SYM_ERR, 16'h0003);
    $display("test symbols done");
    rx.energy = 1'b0;
    cyc(20);
    rd(IDX_MODE_CTL, 16'h2243);
    cyc(60);
    rd(IDX_MODE_CTL, 16'h2241);
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
    cyc(2);
    rd(IDX_MODE_CTL, 16'h0000);
    rd(IDX_SPECIAL, s18);
    rd(IDX_SYM_ERR, 16'h0003);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    rd(IDX_MODE_CTL, 16'h0002);
    rd(IDX_SPECIAL, {8'h40, mode_strap, addr_strap});
    rd(IDX_SYM_ERR, SYM_ERR_RESET);
    cyc(3);
    $display("test energy and resets done");
    conclude();
  end
endmodule
`default_nettype wire
